// File: verilog/uart_rx_device.sv
// receive shift logic, two-entry buffer and status of the serial port
//
// Notes on behaviour
// - software reads ninth bit before data byte
// - each entry keeps ninth bit and errors
// - receive complete set while buffer unread
// - disable flushes buffer, clears receive complete
// - interrupt follows receive complete when enabled
// - handler reads data to clear request
// - error flags ignore status writes
// - software writes zero to error bits
// - error flags raise no interrupt
// - frame error reflects first stop bit
// - only first stop bit is checked
// - overrun: buffer full, frame waits, start
// - overrun marks frames lost before entry
// - successful transfer clears overrun indication
// - parity error zero when checking off
// - upper bit enables, lower selects parity
// - parity result stored per entry
// - disable abandons frame immediately
// - disabled receiver releases serial input pin
// - software drains buffer by reading data
// - short characters read zero upper bits
// - transfer at first stop, ignore second
`include "uart_rx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_rx_device (
	// clock and reset
	input  wire logic   clock,
	input  wire logic   rst,
	// register port
	rx_port_if.device   port,
	// serial line
	input  wire logic   serial_input_pin,
	output var  logic   pin_override
);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic       rxcie_reg;
	logic       rxen_reg;
	logic       parity_en_reg;
	logic       parity_type_reg;
	logic       stop_sel_reg;
	logic [2:0] size_reg;

	wire wr_ctrl_b = port.reg_wr && (port.reg_addr == `ADDR_CTRL_B);
	wire wr_ctrl_c = port.reg_wr && (port.reg_addr == `ADDR_CTRL_C);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxcie_reg       <= 1'b0;
			rxen_reg        <= 1'b0;
			parity_en_reg   <= 1'b0;
			parity_type_reg <= 1'b0;
			stop_sel_reg    <= 1'b0;
			size_reg        <= 3'h0;
		end else begin
			if (wr_ctrl_b) begin
				rxcie_reg <= port.reg_wdata[`CB_RXCIE];
				rxen_reg  <= port.reg_wdata[`CB_RXEN];
			end
			if (wr_ctrl_c) begin
				parity_en_reg   <= port.reg_wdata[`CC_PAR_EN];
				parity_type_reg <= port.reg_wdata[`CC_PAR_TYPE];
				stop_sel_reg    <= port.reg_wdata[`CC_STOP_SEL];
				size_reg <= port.reg_wdata[`CC_SIZE_HI:`CC_SIZE_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// frame reception
	// ------------------------------------------------------------
	uart_rx_pkg::rx_state_t state_reg;
	uart_rx_pkg::rx_state_t state_next;
	logic [15:0] tick_reg;
	logic [3:0]  bit_cnt_reg;
	logic [8:0]  shift_reg;
	logic        par_bit_reg;
	uart_rx_pkg::rx_entry_t hold_reg;
	logic        hold_valid_reg;
	logic        dor_pend_reg;

	// unused high bits stay zero since only sampled bits are written
	wire [3:0] last_bit = (size_reg == `SIZE_NINE) ? 4'h8 :
		{2'h0, size_reg[1:0]} + 4'h4;
	wire tick_zero  = (tick_reg == 16'h0000);
	wire start_seen = state_reg[0] && !serial_input_pin;
	wire par_err    = (^shift_reg) ^ par_bit_reg ^ parity_type_reg;
	wire stop_done  = state_reg[4] && tick_zero;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			uart_rx_pkg::RX_IDLE:
				if (!serial_input_pin)
					state_next = uart_rx_pkg::RX_START;
			uart_rx_pkg::RX_START:
				if (tick_zero)
					state_next = serial_input_pin ?
						uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
			uart_rx_pkg::RX_DATA:
				if (tick_zero && bit_cnt_reg == last_bit)
					state_next = parity_en_reg ?
						uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
			uart_rx_pkg::RX_PARITY:
				if (tick_zero)
					state_next = uart_rx_pkg::RX_STOP;
			uart_rx_pkg::RX_STOP:
				if (tick_zero)
					state_next = uart_rx_pkg::RX_IDLE;
			default:
				state_next = uart_rx_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= uart_rx_pkg::RX_IDLE;
		end else if (!rxen_reg) begin
			state_reg <= uart_rx_pkg::RX_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_reg    <= 16'h0000;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 9'h000;
			par_bit_reg <= 1'b0;
		end else if (start_seen) begin
			tick_reg    <= 16'(`HALF_CYCLES);
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 9'h000;
		end else if (!tick_zero) begin
			tick_reg <= tick_reg - 16'h0001;
		end else if (!state_reg[0]) begin
			tick_reg <= 16'(`BIT_CYCLES);
			if (state_reg[2]) begin
				shift_reg[bit_cnt_reg] <= serial_input_pin;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (state_reg[3])
				par_bit_reg <= serial_input_pin;
		end
	end

	// ------------------------------------------------------------
	// two-entry buffer
	// ------------------------------------------------------------
	uart_rx_pkg::rx_entry_t buf_reg [2];
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] count_reg;

	wire buf_full = (count_reg == 2'h2);
	wire rxc      = (count_reg != 2'h0);
	wire pop      = port.reg_rd && (port.reg_addr == `ADDR_DATA) && rxc;
	wire push     = hold_valid_reg && !buf_full;
	// start while buffer full and frame held
	wire overrun  = start_seen && hold_valid_reg && buf_full;
	uart_rx_pkg::rx_entry_t head;
	assign head = rxc ? buf_reg[rd_ptr_reg] : '0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hold_reg       <= '0;
			hold_valid_reg <= 1'b0;
			dor_pend_reg   <= 1'b0;
		end else if (!rxen_reg) begin
			hold_valid_reg <= 1'b0;
			dor_pend_reg   <= 1'b0;
		end else begin
			if (stop_done) begin
				hold_reg.data <= shift_reg;
				hold_reg.fe   <= !serial_input_pin;
				hold_reg.dor  <= dor_pend_reg;
				hold_reg.upe  <= parity_en_reg && par_err;
				hold_valid_reg <= 1'b1;
			end else if (push || overrun) begin
				hold_valid_reg <= 1'b0;
			end
			// lost frame marks the next stored one
			if (overrun)
				dor_pend_reg <= 1'b1;
			else if (push)
				dor_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
		end else if (push) begin
			buf_reg[wr_ptr_reg] <= '{hold_reg.data, hold_reg.fe,
				hold_reg.dor | dor_pend_reg, hold_reg.upe};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else if (!rxen_reg) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push)
				wr_ptr_reg <= !wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= !rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// ------------------------------------------------------------
	// read port, interrupt and pin
	// ------------------------------------------------------------
	logic [7:0] rdata_reg;
	logic       irq_reg;
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		case (port.reg_addr)
			`ADDR_STATUS: begin
				rd_mux[`ST_RXC] = rxc;
				rd_mux[`ST_FE]  = head.fe;
				rd_mux[`ST_DOR] = head.dor;
				rd_mux[`ST_UPE] = head.upe;
			end
			`ADDR_CTRL_B: begin
				rd_mux[`CB_RXCIE] = rxcie_reg;
				rd_mux[`CB_RXEN]  = rxen_reg;
				rd_mux[`CB_NINTH] = head.data[8];
			end
			`ADDR_CTRL_C: begin
				rd_mux[`CC_PAR_EN]   = parity_en_reg;
				rd_mux[`CC_PAR_TYPE] = parity_type_reg;
				rd_mux[`CC_STOP_SEL] = stop_sel_reg;
				rd_mux[`CC_SIZE_HI:`CC_SIZE_LO] = size_reg;
			end
			`ADDR_DATA:
				rd_mux = head.data[7:0];
			default:
				rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_reg    <= 8'h00;
			irq_reg      <= 1'b0;
			pin_override <= 1'b0;
		end else begin
			if (port.reg_rd)
				rdata_reg <= rd_mux;
			irq_reg <= rxcie_reg && rxc && port.global_irq_enable;
			pin_override <= rxen_reg;
		end
	end

	assign port.reg_rdata = rdata_reg;
	assign port.irq       = irq_reg;

endmodule : uart_rx_device

`default_nettype wire

// File: inc/uart_rx_defines.svh
// constants of the receive buffer block and its controller
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH

// timing
`define CLOCK_HZ        40000000
`define BAUD_HZ         115200
`define BIT_CYCLES      (`CLOCK_HZ / `BAUD_HZ)
`define HALF_CYCLES     (`BIT_CYCLES / 2)

// device register indices
`define ADDR_STATUS     2'h0
`define ADDR_CTRL_B     2'h1
`define ADDR_CTRL_C     2'h2
`define ADDR_DATA       2'h3

// status register bits
`define ST_RXC          7
`define ST_FE           4
`define ST_DOR          3
`define ST_UPE          2

// control b bits
`define CB_RXCIE        7
`define CB_RXEN         4
`define CB_NINTH        1

// control c fields
`define CC_PAR_EN       5
`define CC_PAR_TYPE     4
`define CC_STOP_SEL     3
`define CC_SIZE_HI      2
`define CC_SIZE_LO      0
`define SIZE_NINE       3'h7

// controller axi register offsets
`define AXI_CONFIG      4'h0
`define AXI_COMMAND     4'h4
`define AXI_STATUS      4'h8
`define AXI_DATA        4'hc

// controller config fields
`define CFG_RXEN        0
`define CFG_RXCIE       1
`define CFG_GIE         2
`define CFG_PAR_EN      3
`define CFG_PAR_TYPE    4
`define CFG_STOP_SEL    5
`define CFG_SIZE_LO     6
`define CFG_SIZE_HI     8
`define CFG_RESET       32'h0000_0000

// controller command bits
`define CMD_FETCH       0
`define CMD_FLUSH       1

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: inc/uart_rx_pkg.sv
// types shared by the receive buffer block and its controller
package uart_rx_pkg;

	typedef enum logic [4:0] {
		RX_IDLE   = 5'h01,
		RX_START  = 5'h02,
		RX_DATA   = 5'h04,
		RX_PARITY = 5'h08,
		RX_STOP   = 5'h10
	} rx_state_t;

	typedef enum logic [8:0] {
		C_IDLE    = 9'h001,
		C_CFG_S   = 9'h002,
		C_CFG_C   = 9'h004,
		C_CFG_B   = 9'h008,
		C_F_STAT  = 9'h010,
		C_F_B     = 9'h020,
		C_F_DATA  = 9'h040,
		C_F_END   = 9'h080,
		C_FL_CHK  = 9'h100
	} ctl_state_t;

	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       dor;
		logic       upe;
	} rx_entry_t;

endpackage : uart_rx_pkg

// File: inc/rx_port_if.sv
// register port between the receive block and its controller
`timescale 1ns/1ps
`default_nettype none

interface rx_port_if;
	logic [1:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       irq;
	logic       global_irq_enable;

	modport device (
		input  reg_addr,
		input  reg_wr,
		input  reg_rd,
		input  reg_wdata,
		input  global_irq_enable,
		output reg_rdata,
		output irq
	);

	modport host (
		output reg_addr,
		output reg_wr,
		output reg_rd,
		output reg_wdata,
		output global_irq_enable,
		input  reg_rdata,
		input  irq
	);
endinterface : rx_port_if

`default_nettype wire

// File: verilog/uart_rx_controller.sv
// controller: axi4-lite registers driving the receive block's port
`include "uart_rx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_rx_controller (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// device port
	rx_port_if.host          port,
	// axi4-lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ------------------------------------------------------------
	// axi slave
	// ------------------------------------------------------------
	uart_rx_pkg::ctl_state_t state_reg;
	uart_rx_pkg::ctl_state_t state_next;
	logic [31:0] config_reg;
	logic        cfg_dirty_reg;
	logic [7:0]  stat_cap_reg;
	logic [8:0]  data_cap_reg;

	wire busy   = !state_reg[0];
	wire aw_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
		&& !s_axi_bvalid;
	wire w_done = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	wire w_cfg  = w_done && (s_axi_awaddr == `AXI_CONFIG);
	wire w_cmd  = w_done && (s_axi_awaddr == `AXI_COMMAND) && !busy;
	wire w_map  = (s_axi_awaddr == `AXI_CONFIG) ||
		(s_axi_awaddr == `AXI_COMMAND);
	wire ar_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	wire r_done = s_axi_arready && s_axi_arvalid;
	wire r_map  = (s_axi_araddr[1:0] == 2'h0);
	wire [31:0] stat_word = {26'h0, stat_cap_reg[`ST_UPE],
		stat_cap_reg[`ST_DOR], stat_cap_reg[`ST_FE], port.irq,
		stat_cap_reg[`ST_RXC], busy};
	wire [31:0] rd_word =
		(s_axi_araddr == `AXI_CONFIG) ? config_reg :
		(s_axi_araddr == `AXI_STATUS) ? stat_word :
		(s_axi_araddr == `AXI_DATA)   ? {23'h0, data_cap_reg} : 32'h0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= aw_go;
			s_axi_wready  <= aw_go;
			if (w_done) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_map ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ar_go;
			if (r_done) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= r_map ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// byte strobes ignored: config is one word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			config_reg    <= `CFG_RESET;
			cfg_dirty_reg <= 1'b0;
		end else begin
			if (w_cfg)
				config_reg <= s_axi_wdata;
			if (w_cfg)
				cfg_dirty_reg <= 1'b1;
			else if (state_reg == uart_rx_pkg::C_CFG_S)
				cfg_dirty_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// port sequencer
	// ------------------------------------------------------------
	logic [1:0] addr_next;
	logic       wr_next;
	logic       rd_next;
	logic [7:0] wdata_next;
	logic [1:0] addr_reg;
	logic       wr_reg;
	logic       rd_reg;
	logic [7:0] wdata_reg;
	logic       gie_reg;

	wire [7:0] ctrl_b = ({7'h0, config_reg[`CFG_RXCIE]} << `CB_RXCIE) |
		({7'h0, config_reg[`CFG_RXEN]} << `CB_RXEN);
	wire [7:0] ctrl_c = {2'h0, config_reg[`CFG_PAR_EN],
		config_reg[`CFG_PAR_TYPE], config_reg[`CFG_STOP_SEL],
		config_reg[`CFG_SIZE_HI:`CFG_SIZE_LO]};

	always_comb begin
		state_next = state_reg;
		addr_next  = `ADDR_STATUS;
		wr_next    = 1'b0;
		rd_next    = 1'b0;
		wdata_next = 8'h00;
		case (state_reg)
			uart_rx_pkg::C_IDLE:
				if (cfg_dirty_reg) begin
					wr_next    = 1'b1;
					state_next = uart_rx_pkg::C_CFG_S;
				end else if (w_cmd && s_axi_wdata[`CMD_FETCH]) begin
					rd_next    = 1'b1;
					state_next = uart_rx_pkg::C_F_STAT;
				end else if (w_cmd && s_axi_wdata[`CMD_FLUSH]) begin
					rd_next    = 1'b1;
					state_next = uart_rx_pkg::C_FL_CHK;
				end
			uart_rx_pkg::C_CFG_S: begin
				wr_next    = 1'b1;
				addr_next  = `ADDR_CTRL_C;
				wdata_next = ctrl_c;
				state_next = uart_rx_pkg::C_CFG_C;
			end
			uart_rx_pkg::C_CFG_C: begin
				wr_next    = 1'b1;
				addr_next  = `ADDR_CTRL_B;
				wdata_next = ctrl_b;
				state_next = uart_rx_pkg::C_CFG_B;
			end
			uart_rx_pkg::C_CFG_B:
				state_next = uart_rx_pkg::C_IDLE;
			// status and ninth bit before data
			uart_rx_pkg::C_F_STAT: begin
				rd_next    = 1'b1;
				addr_next  = `ADDR_CTRL_B;
				state_next = uart_rx_pkg::C_F_B;
			end
			uart_rx_pkg::C_F_B: begin
				rd_next    = 1'b1;
				addr_next  = `ADDR_DATA;
				state_next = uart_rx_pkg::C_F_DATA;
			end
			uart_rx_pkg::C_F_DATA:
				state_next = uart_rx_pkg::C_F_END;
			uart_rx_pkg::C_F_END:
				state_next = uart_rx_pkg::C_IDLE;
			uart_rx_pkg::C_FL_CHK:
				if (rd_reg || wr_reg) begin
					state_next = uart_rx_pkg::C_FL_CHK;
				end else if (port.reg_rdata[`ST_RXC]) begin
					rd_next    = 1'b1;
					addr_next  = `ADDR_DATA;
					state_next = uart_rx_pkg::C_F_STAT;
				end else begin
					state_next = uart_rx_pkg::C_IDLE;
				end
			default:
				state_next = uart_rx_pkg::C_IDLE;
		endcase
		// a flush re-polls status after each data read
		if (state_reg == uart_rx_pkg::C_F_STAT && addr_reg == `ADDR_DATA)
		begin
			rd_next    = 1'b1;
			addr_next  = `ADDR_STATUS;
			state_next = uart_rx_pkg::C_FL_CHK;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= uart_rx_pkg::C_IDLE;
			addr_reg  <= `ADDR_STATUS;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			wdata_reg <= 8'h00;
			gie_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			wr_reg    <= wr_next;
			rd_reg    <= rd_next;
			wdata_reg <= wdata_next;
			gie_reg   <= config_reg[`CFG_GIE];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stat_cap_reg <= 8'h00;
			data_cap_reg <= 9'h000;
		end else begin
			if (state_reg == uart_rx_pkg::C_F_B ||
				state_reg == uart_rx_pkg::C_FL_CHK && !rd_reg)
				stat_cap_reg <= port.reg_rdata;
			if (state_reg == uart_rx_pkg::C_F_DATA)
				data_cap_reg[8] <= port.reg_rdata[`CB_NINTH];
			if (state_reg == uart_rx_pkg::C_F_END)
				data_cap_reg[7:0] <= port.reg_rdata;
		end
	end

	assign port.reg_addr          = addr_reg;
	assign port.reg_wr            = wr_reg;
	assign port.reg_rd            = rd_reg;
	assign port.reg_wdata         = wdata_reg;
	assign port.global_irq_enable = gie_reg;

endmodule : uart_rx_controller

`default_nettype wire

// File: test/uart_rx_monitor.sv
// checker of the receive block's register port and serial pin
`timescale 1ns/1ps
`default_nettype none

module uart_rx_monitor (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// device register port
	input wire logic [1:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq,
	input wire logic       global_irq_enable,
	// serial pin ownership
	input wire logic       pin_override
);
	// ----------------------------------------
	// shadow of control writes
	// ----------------------------------------
	logic       rxen_reg;
	logic       rxcie_reg;
	logic       par_seen_reg;
	logic [2:0] size_reg;
	wire logic  wr_b  = reg_wr && reg_addr == 2'h1;
	wire logic  wr_c  = reg_wr && reg_addr == 2'h2;
	wire logic  rd_st = reg_rd && reg_addr == 2'h0;
	wire logic  rd_dt = reg_rd && reg_addr == 2'h3;

	// parity flag only proven while checking never enabled
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxen_reg <= 1'h0;
			rxcie_reg <= 1'h0;
			par_seen_reg <= 1'h0;
			size_reg <= 3'h0;
		end else begin
			if (wr_b) begin
				rxen_reg <= reg_wdata[4];
				rxcie_reg <= reg_wdata[7];
			end
			if (wr_c) begin
				size_reg <= reg_wdata[2:0];
				par_seen_reg <= par_seen_reg | reg_wdata[5];
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	irq_gie_gate_a:
	assert property (!global_irq_enable |=> !irq)
		else $error("irq without global enable");
	irq_ie_gate_a:
	assert property (!rxcie_reg && !$past(rxcie_reg) |-> !irq)
		else $error("irq without receive interrupt enable");
	irq_off_disabled_a:
	assert property (!rxen_reg && !$past(rxen_reg) |=> !irq)
		else $error("irq while receiver disabled");
	rxc_off_disabled_a:
	assert property (rd_st && !rxen_reg && !$past(rxen_reg) |=> !reg_rdata[7])
		else $error("receive complete while receiver disabled");
	pin_follows_en_a:
	assert property (rxen_reg == $past(rxen_reg) |-> pin_override == rxen_reg)
		else $error("pin ownership differs from receiver enable");
	parity_off_zero_a:
	assert property (rd_st && !par_seen_reg |=> !reg_rdata[2])
		else $error("parity error with checking off");
	short_char_zero_a:
	assert property (rd_dt && size_reg < 3'h3
		|=> (reg_rdata >> (size_reg + 3'h5)) == 8'h0)
		else $error("upper data bits set for short character");
	read_data_hold_a:
	assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	cover property ($rose(irq));
	cover property (rd_dt);
	cover property ($fell(rxen_reg));
endmodule : uart_rx_monitor

`default_nettype wire

// File: test/tb.sv
// self-checking bench: controller and receive block over the port
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clock;
	logic        rst;
	logic        serial_line;
	logic        pin_override;
	logic [3:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [3:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [31:0] v;
	int          num_errors = 0;
	int          tests_run = 0;

	rx_port_if port ();
	uart_rx_device u_uart_rx_device (.clock(clock), .rst(rst),
		.port(port.device), .serial_input_pin(serial_line),
		.pin_override(pin_override));
	uart_rx_controller u_uart_rx_controller (.clock(clock), .rst(rst),
		.port(port.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	uart_rx_monitor u_uart_rx_monitor (.clock(clock), .rst(rst),
		.reg_addr(port.reg_addr), .reg_wr(port.reg_wr),
		.reg_rd(port.reg_rd), .reg_wdata(port.reg_wdata),
		.reg_rdata(port.reg_rdata), .irq(port.irq),
		.global_irq_enable(port.global_irq_enable),
		.pin_override(pin_override));

	// ----------------------------------------
	// bus and line tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		check({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : axi_rd

	// poll busy; no fixed latency is assumed for the port walk
	task automatic idle(output logic [31:0] st);
		do begin
			axi_rd(4'h8, st, 2'h0);
		end while (st[0] !== 1'h0);
	endtask : idle

	task automatic cfg(input logic [31:0] c);
		logic [31:0] st;
		axi_wr(4'h0, c, 2'h0);
		idle(st);
		axi_rd(4'h0, st, 2'h0);
		check(st, c);
	endtask : cfg

	// f is {parity err, overrun, frame err, receive complete}
	task automatic got(input logic [8:0] d, input logic [3:0] f);
		logic [31:0] st;
		axi_wr(4'h4, 32'h1, 2'h0);
		idle(st);
		check({28'h0, st[5:3], st[1]}, {28'h0, f});
		axi_rd(4'hc, st, 2'h0);
		check(st, {23'h0, d});
	endtask : got

	// a bad stop gets an idle bit so the next start edge exists
	task automatic send(input logic [8:0] d, input int nb, input int par,
		input logic stp);
		logic b[$];
		b = {1'h0};
		for (int i = 0; i < nb; i++) b.push_back(d[i]);
		if (par >= 0) b.push_back(par[0]);
		b.push_back(stp);
		if (!stp) b.push_back(1'h1);
		@(posedge clock);
		foreach (b[i]) begin
			serial_line <= b[i];
			repeat (347) @(posedge clock);
		end
	endtask : send

	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	// sixteen frames of some 3500 cycles each fit well inside
	initial begin
		repeat (95000) @(posedge clock);
		num_errors++;
		summarize();
	end

	initial begin
		rst = 1'h1;
		serial_line = 1'h1;
		s_axi_awaddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_araddr = 4'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		axi_rd(4'h0, v, 2'h0);
		check(v, 32'h0);
		axi_rd(4'h1, v, 2'h2);
		axi_wr(4'h2, 32'h1, 2'h2);
		cfg(32'h0c7);
		send(9'h0a5, 8, -1, 1'h1);
		check({31'h0, port.irq}, 32'h1);
		axi_rd(4'h8, v, 2'h0);
		check({31'h0, v[2]}, 32'h1);
		got(9'h0a5, 4'h1);
		check({31'h0, port.irq}, 32'h0);
		got(9'h000, 4'h0);
		for (int t = 0; t < 2; t++) begin
			cfg(t ? 32'h0df : 32'h0cf);
			send(9'h001, 8, 0, 1'h1);
			got(9'h001, {~t[0], 3'h1});
		end
		cfg(32'h0e7);
		send(9'h03c, 8, -1, 1'h0);
		send(9'h05a, 8, -1, 1'h1);
		got(9'h03c, 4'h3);
		got(9'h05a, 4'h1);
		cfg(32'h0c7);
		send(9'h011, 8, -1, 1'h1);
		send(9'h022, 8, -1, 1'h1);
		send(9'h033, 8, -1, 1'h1);
		send(9'h044, 8, -1, 1'h1);
		got(9'h011, 4'h1);
		got(9'h022, 4'h1);
		got(9'h044, 4'h5);
		got(9'h000, 4'h0);
		send(9'h055, 8, -1, 1'h1);
		got(9'h055, 4'h1);
		cfg(32'h1c7);
		send(9'h1c3, 9, -1, 1'h1);
		got(9'h1c3, 4'h1);
		cfg(32'h001);
		send(9'h015, 5, -1, 1'h1);
		got(9'h015, 4'h1);
		cfg(32'h0c7);
		send(9'h012, 8, -1, 1'h1);
		send(9'h034, 8, -1, 1'h1);
		axi_wr(4'h4, 32'h2, 2'h0);
		idle(v);
		check({31'h0, v[1]}, 32'h0);
		send(9'h077, 8, -1, 1'h1);
		cfg(32'h0c6);
		check({31'h0, pin_override}, 32'h0);
		got(9'h000, 4'h0);
		cfg(32'h0c7);
		// re-enabled long before the stop bit, on a line held high
		fork
			send(9'h0ff, 8, -1, 1'h1);
			begin
				repeat (1500) @(posedge clock);
				cfg(32'h0c6);
				cfg(32'h0c7);
			end
		join
		got(9'h000, 4'h0);
		summarize();
	end
endmodule : tb

`default_nettype wire
